// >>> verilog/dcb_pkg.sv
// Shared constants for the chirp / phase-keying / update control pair
package dcb_pkg;

    // ------------------------------------------------------------
    // Link geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int BUF_DEPTH = 32;

    // ------------------------------------------------------------
    // Device byte map (first byte of each field is its top byte)
    // ------------------------------------------------------------
    localparam int PH1_ADDR = 'h00;
    localparam int PH2_ADDR = 'h02;
    localparam int PH_BYTES = 2;
    localparam int START_ADDR = 'h04;
    localparam int START_BYTES = 6;
    localparam int STEP_ADDR = 'h10;
    localparam int STEP_BYTES = 6;
    localparam int INTERVAL_ADDR = 'h16;
    localparam int INTERVAL_BYTES = 4;
    localparam int DWELL_ADDR = 'h1a;
    localparam int DWELL_BYTES = 3;
    localparam int CTRL_ADDR = 'h1f;

    // ------------------------------------------------------------
    // Fields of sweep_control
    // ------------------------------------------------------------
    localparam int CTRL_INT_UPD_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_ALL_CLR_BIT = 6;
    localparam int CTRL_FREQ_CLR_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [2:0] MODE_CHIRP = 3'h3;
    localparam logic [2:0] MODE_PHASE_KEY_SELECT_PIN = 3'h4;

    // ------------------------------------------------------------
    // Update clock timing
    // ------------------------------------------------------------
    localparam logic [3:0] UPD_HIGH_CYCLES = 4'h8;
    localparam logic [31:0] UPD_MIN_COUNT = 32'h0000_0005;

    // ------------------------------------------------------------
    // Host command map
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_DEV_LIMIT = 8'h20;
    localparam logic [7:0] HOST_CTRL_ADDR = 8'h20;
    localparam logic [7:0] HOST_UPD_ADDR = 8'h21;
    localparam logic [7:0] HOST_STAT_ADDR = 8'h22;
    localparam int HOST_PIN_BIT = 0;
    localparam int HOST_EXT_BIT = 1;
    localparam logic [3:0] HOST_UPD_HIGH = 4'h4;

endpackage

// >>> verilog/dcb_link_if.sv
// Link between the host controller and the synthesizer control end
`timescale 1ns/1ps
interface dcb_link_if;
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic key_pin;
    logic upd_dev_o;
    logic upd_dev_oe;
    logic upd_host_o;
    logic upd_host_oe;
    logic upd_line;

    // Device drive wins; an undriven line reads low
    assign upd_line = upd_dev_oe ? upd_dev_o :
                      (upd_host_oe ? upd_host_o : 1'b0);

    modport dev (
        input wr, rd, addr, wdata, key_pin, upd_line,
        output rdata, upd_dev_o, upd_dev_oe
    );
    modport host (
        input rdata, upd_line,
        output wr, rd, addr, wdata, key_pin, upd_host_o, upd_host_oe
    );
endinterface

// >>> verilog/dcb_update_gen.sv
// Update strobe source: external pin synchroniser or internal down-counter
`timescale 1ns/1ps
module dcb_update_gen (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic internal_sel,
    input wire logic [31:0] interval,
    input wire logic pin_in,
    output logic update_pulse,
    output logic pin_out,
    output logic pin_oe
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic half_reg;
    logic [31:0] count_reg;
    logic [3:0] high_reg;
    logic pin_reg;
    logic ext_edge;
    logic int_fire;

    // ------------------------------------------------------------
    // External strobe
    // ------------------------------------------------------------
    // Only the second and third stages feed the edge detector
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign ext_edge = sync2_reg & ~sync3_reg; // see RULE15

    // ------------------------------------------------------------
    // Internal counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            half_reg <= 1'b0;
        else
            half_reg <= ~half_reg;
    end

    // Counts on every other edge, so a period is (N+1) twice over
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            count_reg <= 32'h0;
        else if (!internal_sel)
            count_reg <= interval;
        else if (half_reg)
            count_reg <= (count_reg == 32'h0) ? interval
                                               : count_reg - 32'h1; // see RULE17
    end

    assign int_fire = internal_sel & half_reg & (count_reg == 32'h0);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            high_reg <= 4'h0;
        else if (int_fire)
            high_reg <= dcb_pkg::UPD_HIGH_CYCLES;
        else if (high_reg != 4'h0)
            high_reg <= high_reg - 4'h1;
    end

    // Short periods would merge pulses, so the pin just stays high
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pin_reg <= 1'b0;
        else
            pin_reg <= internal_sel & ((interval < dcb_pkg::UPD_MIN_COUNT)
                       | int_fire | (high_reg > 4'h1)); // see RULE18 RULE19
    end

    assign pin_out = pin_reg;
    assign pin_oe = internal_sel;
    assign update_pulse = internal_sel ? int_fire : ext_edge; // see RULE14

endmodule

// >>> verilog/dcb_device.sv
// Synthesizer control end: buffered registers, chirp sweep, phase keying
// What this block does
// RULE1 - Step sign bit sets sweep direction
// RULE2 - Host writes start, step, dwell, then updates
// RULE3 - Sweep never returns home, stays below Nyquist
// RULE4 - Frequency clear: one-cycle accumulator clear pulse
// RULE5 - Held frequency clear repeats each update edge
// RULE6 - Clear-all holds both accumulators at zero
// RULE7 - Registers may be rewritten during clear-all
// RULE8 - Freeze pin stops dwell counter in chirp
// RULE9 - Dwell counter finishes old count before reload
// RULE10 - Zero step word holds current frequency
// RULE11 - Host uses update counter for sawtooth clears
// RULE12 - Keying pin selects first or second offset
// RULE13 - Host loads carrier, offsets, then updates
// RULE14 - Buffers move to core only on update
// RULE15 - External update edge synchronised first
// RULE16 - Internal update source after reset
// RULE17 - Update counter at half rate, N+1 periods
// RULE18 - Internal update pulse high eight cycles
// RULE19 - Count below five keeps pin high
// RULE20 - Dwell counter pulses every N+1 cycles
// RULE21 - Dwell pulse adds step, sum with start
// RULE22 - Mode code 011 is chirp
// RULE23 - Keying adds offset after phase accumulator
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dcb_device (
    input wire logic ref_clk,
    input wire logic rst,
    dcb_link_if.dev link,
    output logic [47:0] tuning_word,
    output logic [13:0] phase_word,
    output logic update_seen
);

    logic [7:0] buf_reg [0:dcb_pkg::BUF_DEPTH-1];
    logic [47:0] start_reg;
    logic [47:0] step_reg;
    logic [19:0] dwell_reg;
    logic [31:0] interval_reg;
    logic [7:0] ctrl_reg;
    logic [13:0] ph1_reg;
    logic [13:0] ph2_reg;
    logic key1_reg;
    logic key2_reg;
    logic fclr_reg;
    logic [19:0] dwell_cnt_reg;
    logic [47:0] facc_reg;
    logic [47:0] pacc_reg;
    logic [47:0] tuning_reg;
    logic [13:0] phase_reg;
    logic seen_reg;
    logic upd;
    logic [2:0] mode;
    logic chirp;
    logic phase_key_select_pin;
    logic all_clr;
    logic dwell_pulse;
    logic [47:0] freq_sum;
    logic [47:0] tuning_next;
    logic [13:0] offset;
    logic addr_ok;

    // ------------------------------------------------------------
    // Buffer registers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [5:0] a);
        int v;
        v = int'(a);
        return (v < dcb_pkg::START_ADDR + dcb_pkg::START_BYTES) ||
               (v >= dcb_pkg::STEP_ADDR &&
                v < dcb_pkg::DWELL_ADDR + dcb_pkg::DWELL_BYTES) ||
               (v == dcb_pkg::CTRL_ADDR);
    endfunction

    function automatic logic [47:0] word_at(input int base, input int n);
        logic [47:0] w;
        w = 48'h0;
        for (int i = 0; i < n; i++)
            w = {w[39:0], buf_reg[base+i]};
        return w;
    endfunction

    assign addr_ok = mapped(link.addr);

    // Writes to mapped bytes are always accepted, also under clear-all
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < dcb_pkg::BUF_DEPTH; i++)
                buf_reg[i] <= (i == dcb_pkg::CTRL_ADDR) ?
                              dcb_pkg::CTRL_RESET : 8'h00;
        end
        else if (link.wr && addr_ok)
            buf_reg[link.addr[4:0]] <= link.wdata; // see RULE7
    end

    // Combinational so the host can register it in the next cycle
    assign link.rdata = (link.rd && addr_ok) ?
                        buf_reg[link.addr[4:0]] : 8'h00;

    // ------------------------------------------------------------
    // Update source
    // ------------------------------------------------------------
    dcb_update_gen u_upd (
        .ref_clk(ref_clk),
        .rst(rst),
        .internal_sel(ctrl_reg[dcb_pkg::CTRL_INT_UPD_BIT]), // see RULE16
        .interval(interval_reg),
        .pin_in(link.upd_line),
        .update_pulse(upd),
        .pin_out(link.upd_dev_o),
        .pin_oe(link.upd_dev_oe)
    );

    // ------------------------------------------------------------
    // Active core registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            start_reg <= 48'h0;
            step_reg <= 48'h0;
            dwell_reg <= 20'h0;
            interval_reg <= 32'h0;
            ctrl_reg <= dcb_pkg::CTRL_RESET; // see RULE16
            ph1_reg <= 14'h0;
            ph2_reg <= 14'h0;
        end
        else if (upd) // see RULE14
        begin
            start_reg <= word_at(dcb_pkg::START_ADDR, dcb_pkg::START_BYTES);
            step_reg <= word_at(dcb_pkg::STEP_ADDR, dcb_pkg::STEP_BYTES);
            dwell_reg <= 20'(word_at(dcb_pkg::DWELL_ADDR,
                                     dcb_pkg::DWELL_BYTES));
            interval_reg <= 32'(word_at(dcb_pkg::INTERVAL_ADDR,
                                        dcb_pkg::INTERVAL_BYTES));
            ctrl_reg <= buf_reg[dcb_pkg::CTRL_ADDR];
            ph1_reg <= 14'(word_at(dcb_pkg::PH1_ADDR, dcb_pkg::PH_BYTES));
            ph2_reg <= 14'(word_at(dcb_pkg::PH2_ADDR, dcb_pkg::PH_BYTES));
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            seen_reg <= 1'b0;
        else
            seen_reg <= upd;
    end

    assign mode = ctrl_reg[dcb_pkg::CTRL_MODE_LSB +: 3];
    assign chirp = (mode == dcb_pkg::MODE_CHIRP); // see RULE22
    assign phase_key_select_pin = (mode == dcb_pkg::MODE_PHASE_KEY_SELECT_PIN);
    assign all_clr = ctrl_reg[dcb_pkg::CTRL_ALL_CLR_BIT];

    // ------------------------------------------------------------
    // Freeze / keying pin
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            key1_reg <= 1'b0;
            key2_reg <= 1'b0;
        end
        else
        begin
            key1_reg <= link.key_pin;
            key2_reg <= key1_reg;
        end
    end

    // ------------------------------------------------------------
    // Accumulator clear one-shot
    // ------------------------------------------------------------
    // Taken from the byte being loaded, so a held bit retriggers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            fclr_reg <= 1'b0;
        else
            fclr_reg <= upd &
                buf_reg[dcb_pkg::CTRL_ADDR][dcb_pkg::CTRL_FREQ_CLR_BIT]; // see RULE4 RULE5
    end

    // ------------------------------------------------------------
    // Dwell counter
    // ------------------------------------------------------------
    // In chirp mode a new dwell value is only picked up when the count hits zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            dwell_cnt_reg <= 20'h0;
        else if (!chirp)
            dwell_cnt_reg <= dwell_reg;
        else if (!key2_reg) // see RULE8
            dwell_cnt_reg <= (dwell_cnt_reg == 20'h0) ? dwell_reg
                             : dwell_cnt_reg - 20'h1; // see RULE9 RULE20
    end

    assign dwell_pulse = chirp & ~key2_reg & (dwell_cnt_reg == 20'h0);

    // ------------------------------------------------------------
    // Frequency accumulator
    // ------------------------------------------------------------
    // Signed step: a set top bit wraps the sum downward
    always_ff @(posedge ref_clk)
    begin
        if (rst || all_clr || fclr_reg) // see RULE4 RULE6
            facc_reg <= 48'h0;
        else if (dwell_pulse)
            facc_reg <= facc_reg + step_reg; // see RULE1 RULE10 RULE21
    end

    assign freq_sum = start_reg + facc_reg; // see RULE21

    // No end point: the top bit is dropped so the word stays below Nyquist
    assign tuning_next = chirp ? {1'b0, freq_sum[46:0]} : start_reg; // see RULE3

    always_ff @(posedge ref_clk)
    begin
        if (rst || all_clr)
            tuning_reg <= 48'h0;
        else
            tuning_reg <= tuning_next; // see RULE23
    end

    // ------------------------------------------------------------
    // Phase accumulator and offset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst || all_clr) // see RULE6
            pacc_reg <= 48'h0;
        else
            pacc_reg <= pacc_reg + tuning_reg;
    end

    assign offset = phase_key_select_pin ? (key2_reg ? ph2_reg : ph1_reg) : 14'h0; // see RULE12

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            phase_reg <= 14'h0;
        else
            phase_reg <= pacc_reg[47:34] + offset; // see RULE23
    end

    assign tuning_word = tuning_reg;
    assign phase_word = phase_reg;
    assign update_seen = seen_reg;

endmodule

// >>> verilog/dcb_host.sv
// Host controller end: forwards software access and drives mode pins
`timescale 1ns/1ps
module dcb_host (
    input wire logic ref_clk,
    input wire logic rst,
    dcb_link_if.host link,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);

    logic [1:0] ctrl_reg;
    logic [3:0] upd_cnt_reg;
    logic upd_pin_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic [7:0] rdata_reg;
    logic to_dev;

    // ------------------------------------------------------------
    // Pass-through to the device
    // ------------------------------------------------------------
    assign to_dev = (addr < dcb_pkg::HOST_DEV_LIMIT);
    assign link.addr = addr[5:0];
    assign link.wdata = wdata;
    assign link.wr = wr & to_dev; // see RULE2 RULE7 RULE13
    assign link.rd = rd & to_dev;

    // ------------------------------------------------------------
    // Host controls
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ctrl_reg <= 2'h0;
        else if (wr && addr == dcb_pkg::HOST_CTRL_ADDR)
            ctrl_reg <= wdata[1:0];
    end

    // Long enough for the device's three-stage synchroniser to see it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            upd_cnt_reg <= 4'h0;
        else if (wr && addr == dcb_pkg::HOST_UPD_ADDR)
            upd_cnt_reg <= dcb_pkg::HOST_UPD_HIGH; // see RULE2 RULE13
        else if (upd_cnt_reg != 4'h0)
            upd_cnt_reg <= upd_cnt_reg - 4'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            upd_pin_reg <= 1'b0;
        else
            upd_pin_reg <= (upd_cnt_reg != 4'h0);
    end

    assign link.upd_host_o = upd_pin_reg;
    assign link.upd_host_oe = ctrl_reg[dcb_pkg::HOST_EXT_BIT];
    assign link.key_pin = ctrl_reg[dcb_pkg::HOST_PIN_BIT];

    // ------------------------------------------------------------
    // Update line monitor and read port
    // ------------------------------------------------------------
    // Lets software pace sawtooth clears to the internal update pulses
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= link.upd_line;
            sync2_reg <= sync1_reg; // see RULE11
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || !rd)
            rdata_reg <= 8'h00;
        else if (to_dev)
            rdata_reg <= link.rdata;
        else if (addr == dcb_pkg::HOST_CTRL_ADDR)
            rdata_reg <= {6'h0, ctrl_reg};
        else if (addr == dcb_pkg::HOST_STAT_ADDR)
            rdata_reg <= {7'h0, sync2_reg};
        else
            rdata_reg <= 8'h00;
    end

    assign rdata = rdata_reg;

endmodule

// >>> testbench/dcb_link_properties.sv
// Concurrent checks on the host / synthesizer control link
`timescale 1ns/1ps
module dcb_link_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr,
    input wire logic rd,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic key_pin,
    input wire logic upd_dev_o,
    input wire logic upd_dev_oe,
    input wire logic upd_host_o,
    input wire logic upd_host_oe,
    input wire logic upd_line
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Byte map of the device side
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [5:0] a);
        return a <= 6'h09 || (a >= 6'h10 && a <= 6'h1c) || a == 6'h1f;
    endfunction

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_reset_internal;
        $fell(rst) |-> upd_dev_oe;
    endproperty
    a_reset_internal: assert property (p_reset_internal)
        else $error("update source is not internal after reset");

    property p_pin_eight;
        $rose(upd_dev_o) && upd_dev_oe |-> upd_dev_o [*8];
    endproperty
    a_pin_eight: assert property (p_pin_eight)
        else $error("internal update pulse shorter than eight cycles");

    property p_line_dev;
        upd_dev_oe |-> upd_line == upd_dev_o;
    endproperty
    a_line_dev: assert property (p_line_dev)
        else $error("update line does not follow the device drive");

    property p_line_host;
        !upd_dev_oe && upd_host_oe |-> upd_line == upd_host_o;
    endproperty
    a_line_host: assert property (p_line_host)
        else $error("update line does not follow the host drive");

    property p_host_four;
        $rose(upd_host_o) |-> upd_host_o [*4] ##1 !upd_host_o;
    endproperty
    a_host_four: assert property (p_host_four)
        else $error("host update strobe is not four cycles high");

    property p_idle_rdata;
        !rd |-> rdata == 8'h00;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data driven without a read");

    // Write then read of the same buffered byte two cycles apart
    property p_readback;
        wr ##2 (rd && addr == $past(addr, 2) && addr >= 6'h04
            && mapped(addr)) |-> rdata == $past(wdata, 2);
    endproperty
    a_readback: assert property (p_readback)
        else $error("buffered byte does not read back");

    property p_unmapped;
        rd && !mapped(addr) |-> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped byte reads nonzero");
endmodule

// >>> testbench/dds_chirp_phase_key_select_pin_update_ctrl_tb.sv
// Self-checking bench for the host / synthesizer control pair
`timescale 1ns/1ps
module dds_chirp_phase_key_select_pin_update_ctrl_tb;
    localparam logic [47:0] mask47 = 48'h7fff_ffff_ffff;
    localparam logic [7:0] ra [5] = '{8'h04, 8'h09, 8'h0c, 8'h1d, 8'h30};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [47:0] tw;
    logic [13:0] pw;
    logic us;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] mdl [64];

    dcb_link_if link ();
    dcb_device i_dcb_device (.ref_clk(ref_clk), .rst(rst), .link(link),
        .tuning_word(tw), .phase_word(pw), .update_seen(us));
    dcb_host i_dcb_host (.ref_clk(ref_clk), .rst(rst), .link(link),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    dcb_link_properties i_dcb_link_properties (
        .ref_clk(ref_clk), .rst(rst), .wr(link.wr), .rd(link.rd),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .key_pin(link.key_pin), .upd_dev_o(link.upd_dev_o),
        .upd_dev_oe(link.upd_dev_oe), .upd_host_o(link.upd_host_o),
        .upd_host_oe(link.upd_host_oe), .upd_line(link.upd_line));

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // Compare, bus and wait tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk_word(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cycles(input int got, input int exp);
        chk_word(48'(got), 48'(exp));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        mdl[a[5:0]] = d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic sw_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Fields go top byte first, as the device expects
    task automatic wr_field(input int a, input int n, input logic [47:0] v);
        for (int i = 0; i < n; i++)
            sw_wr(8'(a + i), v[8*(n-1-i) +: 8]);
    endtask
    function automatic logic [7:0] mdl_rd(input logic [7:0] a);
        if (a <= 8'h09 || (a >= 8'h10 && a <= 8'h1c) || a == 8'h1f)
            return mdl[a[5:0]];
        return 8'h00;
    endfunction
    task automatic wait_upd();
        int i;
        i = 0;
        do
        begin
            tick(1);
            i++;
        end
        while (us !== 1'b1 && i < 200);
        chk_word(48'(us), 48'h1);
    endtask
    task automatic wait_chg(output logic [47:0] v);
        logic [47:0] p;
        int i;
        p = tw;
        i = 0;
        do
        begin
            tick(1);
            i++;
        end
        while (tw === p && i < 200);
        chk_word(48'(tw !== p), 48'h1);
        v = tw;
    endtask
    task automatic seek(input logic [47:0] e, input int n);
        int i;
        i = 0;
        while (tw !== e && i < n)
        begin
            tick(1);
            i++;
        end
        chk_word(tw, e);
    endtask

    // ------------------------------------------------------------
    // Test sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        #50000;
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        logic [7:0] d;
        logic [47:0] s, st, v0, v1;
        logic [13:0] p1, p2;
        int dw, c0, lo, nz;
        void'($urandom(29));
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[6'h1f] = dcb_pkg::CTRL_RESET;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        sw_rd(8'h1f, d);
        chk_word(48'(d), 48'(mdl_rd(8'h1f)));
        foreach (ra[i])
        begin
            sw_wr(ra[i], 8'($urandom));
            sw_rd(ra[i], d);
            chk_word(48'(d), 48'(mdl_rd(ra[i])));
        end
        // Up near the top, down through zero, then a zero step
        for (int k = 0; k < 3; k++)
        begin
            st = 48'(32'h40 + $urandom % 64);
            if (k == 1) st = -st;
            if (k == 2) st = 48'h0;
            s = (k == 0) ? 48'h7fff_ffff_fe00 : 48'h0000_0000_0100;
            dw = 1 + $urandom % 6;
            wr_field(dcb_pkg::START_ADDR, dcb_pkg::START_BYTES, s);
            wr_field(dcb_pkg::STEP_ADDR, dcb_pkg::STEP_BYTES, st);
            wr_field(dcb_pkg::DWELL_ADDR, dcb_pkg::DWELL_BYTES, 48'(dw));
            sw_wr(8'(dcb_pkg::CTRL_ADDR), 8'h07);
            v0 = tw;
            tick(20);
            if (k < 2) wait_chg(v0);
            c0 = cyc;
            if (k == 2)
                chk_word(tw, v0);
            else
            begin
                wait_chg(v1);
                chk_word(v1, (v0 + st) & mask47);
                chk_cycles(cyc - c0, dw + 1);
            end
            if (k == 0)
            begin
                sw_wr(8'h20, 8'h01);
                tick(8);
                v0 = tw;
                tick(30);
                chk_word(tw, v0);
                sw_wr(8'h20, 8'h00);
                wait_chg(v1);
            end
        end
        // Sawtooth: the update counter restarts the sweep each period
        wr_field(dcb_pkg::STEP_ADDR, dcb_pkg::STEP_BYTES, 48'h100);
        wr_field(dcb_pkg::DWELL_ADDR, dcb_pkg::DWELL_BYTES, 48'h1);
        wr_field(dcb_pkg::INTERVAL_ADDR, dcb_pkg::INTERVAL_BYTES, 48'h14);
        sw_wr(8'(dcb_pkg::CTRL_ADDR), 8'h87);
        repeat (2) wait_upd();
        c0 = cyc;
        wait_upd();
        chk_cycles(cyc - c0, 2 * (20 + 1));
        seek(s & mask47, 4);
        wait_chg(v1);
        chk_word(v1, (s + 48'h100) & mask47);
        // Short interval keeps the pin high; clear-all holds zero
        wr_field(dcb_pkg::INTERVAL_ADDR, dcb_pkg::INTERVAL_BYTES, 48'h3);
        sw_wr(8'(dcb_pkg::CTRL_ADDR), 8'h47);
        s = 48'(32'($urandom)) + 48'h1;
        wr_field(dcb_pkg::START_ADDR, dcb_pkg::START_BYTES, s);
        wr_field(dcb_pkg::STEP_ADDR, dcb_pkg::STEP_BYTES, 48'h0);
        tick(100);
        lo = 0;
        nz = 0;
        repeat (40)
        begin
            tick(1);
            if (link.upd_line !== 1'b1) lo++;
            if (tw !== 48'h0) nz++;
        end
        chk_cycles(lo, 0);
        chk_cycles(nz, 0);
        wait_upd();
        sw_wr(8'(dcb_pkg::CTRL_ADDR), 8'h07);
        seek(s, 20);
        // Phase keying with both accumulators parked at zero
        p1 = 14'($urandom);
        p2 = 14'($urandom);
        wr_field(dcb_pkg::START_ADDR, dcb_pkg::START_BYTES, 48'h0);
        wr_field(dcb_pkg::PH1_ADDR, dcb_pkg::PH_BYTES, 48'(p1));
        wr_field(dcb_pkg::PH2_ADDR, dcb_pkg::PH_BYTES, 48'(p2));
        sw_wr(8'(dcb_pkg::CTRL_ADDR), 8'h49);
        tick(20);
        sw_wr(8'(dcb_pkg::CTRL_ADDR), 8'h09);
        tick(20);
        chk_word(48'(pw), 48'(p1));
        sw_wr(8'h20, 8'h01);
        tick(8);
        chk_word(48'(pw), 48'(p2));
        // External strobe: nothing moves until the host pulses the pin
        sw_wr(8'h20, 8'h02);
        sw_wr(8'(dcb_pkg::CTRL_ADDR), 8'h00);
        tick(20);
        chk_word(48'(link.upd_dev_oe), 48'h0);
        s = 48'(32'($urandom));
        wr_field(dcb_pkg::START_ADDR, dcb_pkg::START_BYTES, s);
        tick(30);
        chk_word(tw, 48'h0);
        sw_wr(dcb_pkg::HOST_UPD_ADDR, 8'h00);
        wait_upd();
        tick(2);
        chk_word(tw, s);
        tally_and_finish();
    end
endmodule
